// *** wdt_defines.svh ***
// register map, field positions and timing constants of the two-stage watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_PORT_ADDR        16'h0079
`define WDT_ADDR_W           16
`define WDT_DATA_W           8
`define WDT_REG_RESET        8'h00

`define WDT_SEL_LSB          0
`define WDT_SEL_MSB          2
`define WDT_RST_EN_BIT       3
`define WDT_NMI_EN_BIT       4
`define WDT_SUPPLY_FLAG_BIT  5
`define WDT_NMI_SEEN_BIT     6
`define WDT_RST_FLAG_BIT     7

`define WDT_SLOW_MAX_HZ      32
`define WDT_MS_PER_S         1000
`define WDT_WARN_MS          250
`define WDT_P0_MS            1000
`define WDT_P1_MS            500
`define WDT_P2_MS            250
`define WDT_P3_MS            2000
`define WDT_P4_MS            8000
`define WDT_P5_MS            32000
`define WDT_P6_MS            128000
`define WDT_P7_MS            256000
// least time: round up to whole ticks of the fastest slow clock
`define WDT_MS_TO_TICKS(ms)  (((ms) * `WDT_SLOW_MAX_HZ + `WDT_MS_PER_S - 1) / `WDT_MS_PER_S)
`define WDT_TICK_W           14
`define WDT_RST_HOLD_DEF     200000
`define WDT_HOLD_W           20

`endif

// *** wdt_pkg.sv ***
// types shared by the watchdog design
package wdt_pkg;
    typedef enum logic [1:0] {st_count, st_warn, st_reset} watch_state_type;
endpackage

// *** wdt_sync.sv ***
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module wdt_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage1;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            stage1 <= '0;
            o_sync <= '0;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// *** wdt_tick_counter.sv ***
// slow-tick counter with synchronous clear, saturating at all ones
`timescale 1ns/1ps
module wdt_tick_counter #(
    parameter int W = 14
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic         i_clear,
    input  wire logic         i_tick,
    output logic      [W-1:0] o_count
);
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || i_clear)
            o_count <= '0;
        else if (i_tick && !(&o_count))
            o_count <= o_count + 1'b1;
    end
endmodule

// *** wdt_top.sv ***
// two-stage watchdog with its control and status port
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_top
    import wdt_pkg::*;
#(
    parameter int RESET_HOLD_CYCLES = `WDT_RST_HOLD_DEF
) (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset,
    input  wire logic [`WDT_ADDR_W-1:0] i_io_addr,
    input  wire logic                   i_io_rd,
    input  wire logic                   i_io_wr,
    input  wire logic [`WDT_DATA_W-1:0] i_io_wdata,
    input  wire logic                   i_slow_clk,
    input  wire logic                   i_supply_fault,
    output logic      [`WDT_DATA_W-1:0] o_io_rdata,
    output logic                        o_io_rdata_valid,
    output logic                        o_nmi,
    output logic                        o_sys_reset
);
    localparam logic [`WDT_TICK_W-1:0] WARN_TICKS = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_WARN_MS));
    localparam logic [`WDT_HOLD_W-1:0] HOLD_LAST  = `WDT_HOLD_W'(RESET_HOLD_CYCLES - 1);

    logic [1:0]             pin_sync;
    logic                   slow_prev;
    logic                   tick;
    logic                   addr_hit;
    logic                   strobe;
    logic                   write;
    logic [2:0]             period_sel;
    logic                   rst_en;
    logic                   nmi_en;
    logic                   supply_flag;
    logic                   nmi_seen;
    logic                   wdt_rst_flag;
    logic [`WDT_DATA_W-1:0] reg_value;
    watch_state_type        state;
    watch_state_type        next_state;
    logic [`WDT_TICK_W-1:0] period_cnt;
    logic [`WDT_TICK_W-1:0] warn_cnt;
    logic [`WDT_TICK_W-1:0] period_limit;
    logic                   period_clear;
    logic                   period_tick;
    logic                   warn_clear;
    logic                   warn_tick;
    logic                   period_done;
    logic                   warn_done;
    logic [`WDT_HOLD_W-1:0] hold_cnt;

    function automatic logic [`WDT_TICK_W-1:0] period_ticks(input logic [2:0] sel);
        logic [`WDT_TICK_W-1:0] t;
        t = '0;
        case (sel)
            3'h0: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P0_MS));
            3'h1: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P1_MS));
            3'h2: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P2_MS));
            3'h3: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P3_MS));
            3'h4: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P4_MS));
            3'h5: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P5_MS));
            3'h6: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P6_MS));
            default: t = `WDT_TICK_W'(`WDT_MS_TO_TICKS(`WDT_P7_MS));
        endcase
        return t;
    endfunction

    // slow clock and supply fault come from other domains
    // only the second flop is read, so a metastable first stage never fans out
    wdt_sync #(
        .W (2)
    ) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_async   ({i_supply_fault, i_slow_clk}),
        .o_sync    (pin_sync)
    );

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            slow_prev <= 1'b0;
        else
            slow_prev <= pin_sync[0];
    end

    assign tick = pin_sync[0] && !slow_prev;

    // address decode
    always_comb
    begin
        if (i_io_addr == `WDT_PORT_ADDR)
            addr_hit = 1'b1;
        else
            addr_hit = 1'b0;
    end

    assign strobe = i_io_rd && addr_hit;
    assign write  = i_io_wr && addr_hit;

    // control bits; i_reset is the power-up reset only, system resets never reach here
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            period_sel <= 3'h0;
            rst_en     <= 1'b0;
            nmi_en     <= 1'b0;
        end
        else if (write)
        begin
            period_sel <= i_io_wdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
            rst_en     <= i_io_wdata[`WDT_RST_EN_BIT];
            nmi_en     <= i_io_wdata[`WDT_NMI_EN_BIT];
        end
    end

    // status flags have no clear but power-up, so no set/clear race exists
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            supply_flag  <= 1'b0;
            nmi_seen     <= 1'b0;
            wdt_rst_flag <= 1'b0;
        end
        else
        begin
            if (pin_sync[1])
                supply_flag <= 1'b1;
            // follows the interrupt output itself, so an enable written mid-warning still leaves a trace
            if (next_state == st_warn && nmi_en)
                nmi_seen <= 1'b1;
            if (next_state == st_reset && state != st_reset)
                wdt_rst_flag <= 1'b1;
        end
    end

    assign reg_value = {wdt_rst_flag, nmi_seen, supply_flag, nmi_en, rst_en, period_sel};

    // data holds between reads; only the valid pulse marks a fresh answer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_io_rdata       <= `WDT_REG_RESET;
            o_io_rdata_valid <= 1'b0;
        end
        else
        begin
            o_io_rdata_valid <= strobe;
            if (strobe)
                o_io_rdata <= reg_value;
        end
    end

    assign period_limit = period_ticks(period_sel);
    assign period_clear = strobe || state != st_count;
    assign period_tick  = tick && state == st_count;
    assign warn_clear   = strobe || state != st_warn;
    assign warn_tick    = tick && state == st_warn;

    wdt_tick_counter #(
        .W (`WDT_TICK_W)
    ) u_period_cnt (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_clear   (period_clear),
        .i_tick    (period_tick),
        .o_count   (period_cnt)
    );

    wdt_tick_counter #(
        .W (`WDT_TICK_W)
    ) u_warn_cnt (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_clear   (warn_clear),
        .i_tick    (warn_tick),
        .o_count   (warn_cnt)
    );

    // one extra edge: the first slow edge may land just after the strobe
    assign period_done = period_cnt > period_limit;
    assign warn_done   = warn_cnt > WARN_TICKS;

    always_comb
    begin
        next_state = state;
        case (state)
            st_count:
                if (!strobe && period_done)
                    next_state = st_warn;
            st_warn:
                if (strobe)
                    next_state = st_count;
                else if (warn_done)
                    next_state = rst_en ? st_reset : st_count;
            st_reset:
                // strobes here are answered but cannot cut the reset pulse short
                if (hold_cnt == HOLD_LAST)
                    next_state = st_count;
            default:
                next_state = st_count;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            state <= st_count;
        else
            state <= next_state;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || state != st_reset)
            hold_cnt <= '0;
        else
            hold_cnt <= hold_cnt + 1'b1;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_nmi       <= 1'b0;
            o_sys_reset <= 1'b0;
        end
        else
        begin
            o_nmi       <= next_state == st_warn && nmi_en;
            o_sys_reset <= next_state == st_reset;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    a_strobe_clears_count: assert property (strobe |=> period_cnt == '0)
        else $error("strobe read did not restart the count");
    a_nmi_needs_enable: assert property ($rose(o_nmi) |-> $past(nmi_en))
        else $error("interrupt raised while disabled");
    a_reset_needs_enable: assert property ($rose(o_sys_reset) |-> $past(rst_en))
        else $error("reset raised while disabled");
    a_warn_before_reset: assert property ($rose(o_sys_reset) |-> $past(state) == st_warn)
        else $error("reset not preceded by warning stage");
    a_warn_full_length: assert property (state == st_warn && next_state == st_reset |-> warn_cnt > WARN_TICKS)
        else $error("warning stage shorter than 250 ms");
    a_no_early_expiry: assert property (state == st_count && next_state == st_warn
                                        |-> period_cnt > period_ticks(period_sel))
        else $error("expiry before the selected period");
    a_seen_flag_set: assert property ($rose(o_nmi) |-> nmi_seen)
        else $error("interrupt seen flag not set with interrupt");
    a_flags_sticky: assert property (nmi_seen |=> nmi_seen)
        else $error("interrupt seen flag cleared without power-up");
    a_rst_flag_sticky: assert property (wdt_rst_flag |=> wdt_rst_flag)
        else $error("watchdog reset flag cleared without power-up");
    a_supply_sticky: assert property (supply_flag |=> supply_flag)
        else $error("supply fault flag cleared without power-up");
    a_rst_flag_set: assert property ($rose(o_sys_reset) |-> wdt_rst_flag)
        else $error("watchdog reset flag not set");
    a_nmi_alone: assert property (state == st_warn && !rst_en && warn_done && !strobe
                                  |=> state == st_count && !o_sys_reset)
        else $error("interrupt-only stage did not return to counting");
    a_count_on_tick: assert property (!$past(period_tick) && !$past(period_clear) |-> $stable(period_cnt))
        else $error("count moved without a slow clock edge");
    a_read_answer: assert property (strobe |=> o_io_rdata_valid ##1 !o_io_rdata_valid || $past(strobe))
        else $error("read answer missing");
    a_read_data: assert property (strobe |=> o_io_rdata == $past(reg_value))
        else $error("read answer does not carry the register value");
    a_valid_only_read: assert property (o_io_rdata_valid |-> $past(strobe))
        else $error("read answer without a read");
    a_strobe_ends_warn: assert property (state == st_warn && strobe |=> !o_nmi)
        else $error("strobe did not end the warning");
    a_power_up_clear: assert property (@(posedge i_ref_clk) disable iff (1'b0)
                                       i_reset |=> !rst_en && !nmi_en && !nmi_seen && !wdt_rst_flag && !o_nmi)
        else $error("power-up left bits set");

    c_nmi_raised: cover property ($rose(o_nmi));
    c_reset_raised: cover property ($rose(o_sys_reset));
    c_strobe_in_warn: cover property (state == st_warn && strobe);
    c_warn_alone: cover property (state == st_warn && !rst_en && warn_done);
endmodule

// *** tb.sv ***
// self-checking testbench of the two-stage watchdog
`timescale 1ns/1ps
`include "wdt_defines.svh"
module tb;
    localparam int                  HOLD = 4;
    localparam logic [`WDT_ADDR_W-1:0] PORT = `WDT_PORT_ADDR;
    logic                           i_ref_clk = 1'b0;
    logic                           i_reset = 1'b1;
    logic [`WDT_ADDR_W-1:0]         i_io_addr = 16'h0000;
    logic                           i_io_rd = 1'b0;
    logic                           i_io_wr = 1'b0;
    logic [`WDT_DATA_W-1:0]         i_io_wdata = 8'h00;
    logic                           i_slow_clk = 1'b0;
    logic                           i_supply_fault = 1'b0;
    logic [`WDT_DATA_W-1:0]         o_io_rdata;
    logic                           o_io_rdata_valid;
    logic                           o_nmi;
    logic                           o_sys_reset;
    int                             err_total = 0;
    int                             check_count = 0;
    int                             seed = 95388;
    int                             rst_seen = 0;
    int                             nmi_seen = 0;
    logic [7:0]                     d;
    logic [7:0]                     w;
    logic [15:0]                    a;

    wdt_top #(.RESET_HOLD_CYCLES(HOLD)) i_wdt_top (
        .i_ref_clk        (i_ref_clk),
        .i_reset          (i_reset),
        .i_io_addr        (i_io_addr),
        .i_io_rd          (i_io_rd),
        .i_io_wr          (i_io_wr),
        .i_io_wdata       (i_io_wdata),
        .i_slow_clk       (i_slow_clk),
        .i_supply_fault   (i_supply_fault),
        .o_io_rdata       (o_io_rdata),
        .o_io_rdata_valid (o_io_rdata_valid),
        .o_nmi            (o_nmi),
        .o_sys_reset      (o_sys_reset)
    );

    always #2.5 i_ref_clk = ~i_ref_clk;

    // output activity counters, sampled where outputs are settled
    always @(negedge i_ref_clk)
    begin
        if (o_sys_reset === 1'b1)
            rst_seen++;
        if (o_nmi === 1'b1)
            nmi_seen++;
    end

    // least whole ticks of the fastest slow clock that cover a period
    function automatic int ticks_of(input int sel);
        int ms;
        case (sel)
            0: ms = 1000;
            1: ms = 500;
            2: ms = 250;
            3: ms = 2000;
            4: ms = 8000;
            5: ms = 32000;
            6: ms = 128000;
            default: ms = 256000;
        endcase
        return (ms * 32 + 999) / 1000;
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic io_write(input logic [15:0] adr, input logic [7:0] dat);
        @(negedge i_ref_clk);
        i_io_addr = adr;
        i_io_wdata = dat;
        i_io_wr = 1'b1;
        @(negedge i_ref_clk);
        i_io_wr = 1'b0;
    endtask

    task automatic io_read(input logic [15:0] adr, input logic hit, output logic [7:0] dat);
        @(negedge i_ref_clk);
        i_io_addr = adr;
        i_io_rd = 1'b1;
        @(negedge i_ref_clk);
        check("rdata_valid", {7'h00, o_io_rdata_valid}, {7'h00, hit});
        dat = o_io_rdata;
        i_io_rd = 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] r;
        io_read(PORT, 1'b1, r);
        check("register", r & m, e);
    endtask

    // each slow period is 8 fast cycles; the edge is fully absorbed before return
    task automatic tick(input int n);
        repeat (n)
        begin
            @(negedge i_ref_clk);
            i_slow_clk = 1'b1;
            repeat (4) @(negedge i_ref_clk);
            i_slow_clk = 1'b0;
            repeat (3) @(negedge i_ref_clk);
        end
    endtask

    task automatic power_up;
        int k;
        @(negedge i_ref_clk);
        i_reset = 1'b1;
        for (k = 0; k < 4; k++)
        begin
            @(negedge i_ref_clk);
            check("outputs_in_reset", {6'h00, o_nmi, o_sys_reset}, 8'h00);
        end
        i_reset = 1'b0;
    endtask

    initial
    begin
        power_up();
        reg_chk(8'hFF, 8'h00);
        $display("test power_up done");
        for (int i = 0; i < 8; i++)
        begin
            w = (i == 7) ? 8'hFF : 8'($random(seed));
            io_write(PORT, w);
            reg_chk(8'hFF, {3'b000, w[4:0]});
            a = 16'($random(seed));
            if (a == PORT)
                a = a ^ 16'h0100;
            io_write(a, ~w);
            io_read(a, 1'b0, d);
            check("miss_rdata", d, {3'b000, w[4:0]});
            reg_chk(8'hFF, {3'b000, w[4:0]});
        end
        $display("test register_access done");
        for (int s = 0; s < 6; s++)
        begin
            io_write(PORT, 8'h10 | 8'(s));
            reg_chk(8'hBF, 8'h10 | 8'(s));
            rst_seen = 0;
            tick(ticks_of(s));
            check("nmi_early", {7'h00, o_nmi}, 8'h00);
            tick(1);
            check("nmi_late", {7'h00, o_nmi}, 8'h01);
            reg_chk(8'hFF, 8'h50 | 8'(s));
            repeat (2) @(negedge i_ref_clk);
            check("nmi_cleared", {7'h00, o_nmi}, 8'h00);
            check("reset_quiet", 8'(rst_seen), 8'h00);
        end
        $display("test periods done");
        io_write(PORT, 8'h12);
        reg_chk(8'hBF, 8'h12);
        tick(6);
        reg_chk(8'hBF, 8'h12);
        tick(6);
        check("restart", {7'h00, o_nmi}, 8'h00);
        tick(3);
        check("alone_nmi", {7'h00, o_nmi}, 8'h01);
        rst_seen = 0;
        tick(9);
        check("alone_end", {7'h00, o_nmi}, 8'h00);
        check("alone_no_reset", 8'(rst_seen), 8'h00);
        reg_chk(8'h40, 8'h40);
        $display("test strobe_restart done");
        io_write(PORT, 8'h1A);
        reg_chk(8'hBF, 8'h1A);
        rst_seen = 0;
        tick(9);
        check("warn_nmi", {7'h00, o_nmi}, 8'h01);
        tick(8);
        check("warn_hold", {7'h00, o_nmi}, 8'h01);
        check("warn_no_reset", 8'(rst_seen), 8'h00);
        tick(1);
        repeat (2) @(negedge i_ref_clk);
        check("reset_width", 8'(rst_seen), 8'(HOLD));
        check("nmi_after_reset", {7'h00, o_nmi}, 8'h00);
        reg_chk(8'hFF, 8'hDA);
        $display("test two_stage done");
        power_up();
        reg_chk(8'hFF, 8'h00);
        io_write(PORT, 8'h0A);
        reg_chk(8'hFF, 8'h0A);
        rst_seen = 0;
        nmi_seen = 0;
        tick(18);
        repeat (2) @(negedge i_ref_clk);
        check("nmi_masked", 8'(nmi_seen), 8'h00);
        check("reset_only", 8'(rst_seen), 8'(HOLD));
        reg_chk(8'hFF, 8'h8A);
        $display("test reset_only done");
        i_supply_fault = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        reg_chk(8'h20, 8'h20);
        i_supply_fault = 1'b0;
        power_up();
        reg_chk(8'hFF, 8'h00);
        $display("test supply_fault done");
        results();
    end
endmodule
